// >>> hw/oms_regs.vh
// Constants of the operation mode supervisor
`ifndef OMS_REGS_VH
`define OMS_REGS_VH
// Register byte offsets
`define OMS_REG_CTRL 4'h0
`define OMS_REG_STATUS 4'h4
`define OMS_REG_SUPPLY 4'h8
// Control register fields
`define OMS_CTRL_CHAN_LSB 0
`define OMS_CTRL_CHAN_MSB 7
`define OMS_CTRL_STAY_BIT 8
`define OMS_CTRL_RESET 9'h000
// Status register fields
`define OMS_STAT_MODE_LSB 0
`define OMS_STAT_MODE_MSB 1
`define OMS_STAT_TERR_BIT 2
`define OMS_STAT_OUT_LSB 8
`define OMS_STAT_OUT_MSB 15
// Mode field encodings
`define OMS_MODE_SLEEP 2'h0
`define OMS_MODE_LIMP 2'h1
`define OMS_MODE_IDLE 2'h2
`define OMS_MODE_ACTIVE 2'h3
// Limp channel mapping
`define OMS_LIMP_CH_IN0 2
`define OMS_LIMP_CH_IN1 3
// Mode transition latency in ns, cycles at 50 ns
`define OMS_TRANS_NS 1000
`define OMS_CLK_NS 50
`define OMS_TRANS_CYC 8'h14
`endif

// >>> hw/oms_operation_mode_supervisor.v
// Operation mode supervisor of an eight channel high-side switch
`timescale 1ns/1ps
`include "oms_regs.vh"
module oms_operation_mode_supervisor (
  input wire i_clk,
  input wire i_rst,
  input wire i_low_power_ctrl,
  input wire [1:0] i_direct_input_pins,
  input wire i_analog_uv,
  input wire i_analog_op,
  input wire i_logic_uv,
  input wire i_logic_low_power,
  input wire i_chip_select_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output reg [7:0] o_channel_out,
  output reg [1:0] o_mode,
  output wire o_uv_monitor_en,
  output wire o_serial_enable,
  output wire o_serial_out_en,
  output wire o_slow_serial_clk,
  output wire o_registers_in_reset
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam ST_SLEEP = 4'h1;
  localparam ST_IDLE = 4'h2;
  localparam ST_ACTIVE = 4'h4;
  localparam ST_LIMP = 4'h8;

  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg [2:0] sync_s1;
  reg [2:0] sync_s2;
  wire ctrl_s;
  wire [1:0] din_s;

  // Supplies are asynchronous comparator levels, so they sync too
  always @(posedge i_clk) begin
    sync_a <= {i_low_power_ctrl, i_direct_input_pins};
    sync_b <= sync_a;
    sync_s1 <= {i_analog_uv, i_logic_uv, i_logic_low_power};
    sync_s2 <= sync_s1;
  end
  assign ctrl_s = sync_b[2];
  assign din_s = sync_b[1:0];
  wire a_uv = sync_s2[2];
  wire l_uv = sync_s2[1];
  reg a_op1;
  reg a_op2;
  reg csn1;
  reg csn2;
  always @(posedge i_clk) begin
    a_op1 <= i_analog_op;
    a_op2 <= a_op1;
    csn1 <= i_chip_select_n;
    csn2 <= csn1;
  end

  // ----------------------------------------------------------------
  // Register file and reset conditions
  // ----------------------------------------------------------------
  reg [3:0] state;
  reg [3:0] next_state;
  reg [7:0] chan_bits;
  reg stay_active;
  reg terr;
  reg limp_seen_cmd;
  wire any_in = |din_s;
  // Sleep: both the monitors and the serial port are switched off
  wire asleep = ~ctrl_s & ~any_in;
  assign o_uv_monitor_en = ~asleep;
  // Control low or logic undervoltage hold the control register at default, and the error flag outside limp
  wire reg_rst = ~ctrl_s | l_uv;
  assign o_registers_in_reset = reg_rst;
  wire serial_ok = ~asleep & ~l_uv;
  assign o_serial_enable = serial_ok;
  assign o_serial_out_en = serial_ok & ~csn2;
  // Informs the serial front end of the 1 MHz limit
  assign o_slow_serial_clk = sync_s2[0] & ~l_uv;
  wire is_limp = state == ST_LIMP;
  wire bus_req = i_avs_read | i_avs_write;
  // Reads stall one cycle so that registered read data already stand
  // at the edge where the master sees waitrequest low; writes never wait
  reg rd_valid;
  always @(posedge i_clk) begin
    if (i_rst)
      rd_valid <= 1'b0;
    else
      rd_valid <= i_avs_read & ~rd_valid;
  end
  assign o_avs_waitrequest = i_avs_read & ~rd_valid;
  wire wr_ok = i_avs_write & ~is_limp & ~reg_rst;

  // Control writes; limp refuses them and flags the first command
  always @(posedge i_clk) begin
    if (i_rst | reg_rst) begin
      chan_bits <= 8'h00;
      stay_active <= 1'b0;
    end else if (wr_ok && i_avs_address == `OMS_REG_CTRL) begin
      chan_bits <= i_avs_writedata[`OMS_CTRL_CHAN_MSB:`OMS_CTRL_CHAN_LSB];
      stay_active <= i_avs_writedata[`OMS_CTRL_STAY_BIT];
    end
  end
  // Status read clears the error flag; decoded in two places below
  function status_rd;
    input rd;
    input [3:0] adr;
    begin
      status_rd = rd && adr == `OMS_REG_STATUS;
    end
  endfunction

  // Error flag: set wins over the clear that a status read performs
  always @(posedge i_clk) begin
    if (i_rst | (reg_rst & ~is_limp)) begin
      terr <= 1'b0;
      limp_seen_cmd <= 1'b0;
    end else if (!is_limp) begin
      limp_seen_cmd <= 1'b0;
      if (status_rd(i_avs_read, i_avs_address))
        terr <= 1'b0;
    end else if (bus_req && !limp_seen_cmd) begin
      terr <= 1'b1;
      limp_seen_cmd <= 1'b1;
    end else if (status_rd(i_avs_read, i_avs_address)) begin
      terr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  wire ch_req = |chan_bits;
  // Any reason to keep channels driven from the serial side or the pins
  wire wake_req = any_in | ch_req | stay_active;
  // Limp needs an input high and at least one supply out of undervoltage
  wire limp_go = any_in & ~(a_uv & l_uv);

  // Each state is written out so that its exits read on their own; the
  // control pin is looked at first because it overrides every bit
  always @* begin
    next_state = state;
    case (state)
      ST_SLEEP: begin
        if (!ctrl_s) begin
          if (limp_go)
            next_state = ST_LIMP;
        end else if (wake_req) begin
          next_state = ST_ACTIVE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!ctrl_s) begin
          if (limp_go)
            next_state = ST_LIMP;
          else
            next_state = ST_SLEEP;
        end else if (wake_req) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!ctrl_s) begin
          if (limp_go)
            next_state = ST_LIMP;
          else
            next_state = ST_SLEEP;
        end else if (!wake_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_LIMP: begin
        // Both supplies low take limp away, so the device falls asleep
        if (!ctrl_s) begin
          if (!limp_go)
            next_state = ST_SLEEP;
        end else if (wake_req) begin
          next_state = ST_ACTIVE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_SLEEP;
    endcase
  end

  // Transition latency counter delays channel turn-on
  reg [7:0] lat_cnt;
  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_SLEEP;
      lat_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (next_state != state)
        lat_cnt <= `OMS_TRANS_CYC;
      else if (lat_cnt != 8'h00)
        lat_cnt <= lat_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Channel drive
  // ----------------------------------------------------------------
  wire [7:0] in_map;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_map
      if (g == `OMS_LIMP_CH_IN0)
        assign in_map[g] = din_s[0];
      else if (g == `OMS_LIMP_CH_IN1)
        assign in_map[g] = din_s[1];
      else
        assign in_map[g] = 1'b0;
    end
  endgenerate

  // Requests: SPI bits ignored under logic undervoltage
  wire [7:0] want = (l_uv ? 8'h00 : chan_bits) | in_map;
  reg [7:0] next_out;
  always @* begin
    next_out = 8'h00;
    if (state == ST_ACTIVE)
      next_out = want;
    else if (state == ST_LIMP)
      next_out = in_map;
    if (lat_cnt != 8'h00)
      next_out = next_out & o_channel_out;
    if (a_uv)
      next_out = 8'h00;
    else if (!a_op2)
      next_out = next_out & o_channel_out;
  end

  // Idle and sleep force all channels off
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_channel_out <= 8'h00;
      o_mode <= `OMS_MODE_SLEEP;
    end else begin
      o_channel_out <= next_out;
      case (next_state)
        ST_LIMP: o_mode <= `OMS_MODE_LIMP;
        ST_IDLE: o_mode <= `OMS_MODE_IDLE;
        ST_ACTIVE: o_mode <= `OMS_MODE_ACTIVE;
        default: o_mode <= `OMS_MODE_SLEEP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered against the request
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read & ~rd_valid) begin
      // Captured once per read, in the stall cycle
      case (i_avs_address)
        `OMS_REG_CTRL:
          o_avs_readdata <= {23'h000000, stay_active, chan_bits};
        `OMS_REG_STATUS:
          o_avs_readdata <= {16'h0000, o_channel_out, 5'h00, terr, o_mode};
        `OMS_REG_SUPPLY:
          o_avs_readdata <= {28'h0000000, sync_s2[0], a_op2, l_uv, a_uv};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // oms_operation_mode_supervisor

// >>> test/oms_sup_asserts.sv
// Port checker for the operation mode supervisor
`timescale 1ns/1ps
`include "oms_regs.vh"
module oms_sup_asserts (
  input wire i_clk,
  input wire i_rst,
  input wire i_low_power_ctrl,
  input wire [1:0] i_direct_input_pins,
  input wire i_analog_uv,
  input wire i_logic_uv,
  input wire [7:0] o_channel_out,
  input wire [1:0] o_mode,
  input wire o_uv_monitor_en,
  input wire o_serial_enable,
  input wire o_serial_out_en,
  input wire o_registers_in_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Pin levels held long enough to pass the synchronisers and settle
  sequence s_sleep;
    (!i_low_power_ctrl && i_direct_input_pins == 2'h0) [*8];
  endsequence
  sequence s_limp;
    (!i_low_power_ctrl && |i_direct_input_pins && !i_logic_uv) [*8];
  endsequence
  sequence s_wake;
    (i_low_power_ctrl && |i_direct_input_pins) [*8];
  endsequence
  chk_sleep_mode: assert property (s_sleep |-> o_mode == `OMS_MODE_SLEEP)
    else $error("sleep mode not entered");
  chk_sleep_quiet: assert property (
    s_sleep |-> !o_serial_out_en && !o_uv_monitor_en)
    else $error("serial output or monitors active in sleep");
  chk_limp_mode: assert property (s_limp |-> o_mode == `OMS_MODE_LIMP)
    else $error("limp home not entered");
  chk_limp_map: assert property (
    o_mode == `OMS_MODE_LIMP |-> (o_channel_out & 8'hF3) == 8'h00)
    else $error("unmapped channel on in limp home");
  chk_wake_active: assert property (
    s_wake |-> o_mode == `OMS_MODE_ACTIVE)
    else $error("active mode not entered");
  chk_idle_off: assert property (
    o_mode == `OMS_MODE_IDLE && $past(o_mode) == `OMS_MODE_IDLE
    |-> o_channel_out == 8'h00)
    else $error("channel on in idle");
  chk_ctrl_reset: assert property (
    !i_low_power_ctrl [*4] |-> o_registers_in_reset)
    else $error("registers not reset with control low");
  chk_logic_uv: assert property (
    i_logic_uv [*4] |-> o_registers_in_reset && !o_serial_enable)
    else $error("serial not blocked in logic undervoltage");
  chk_analog_uv: assert property (
    i_analog_uv [*5] |-> o_channel_out == 8'h00)
    else $error("channel on in analog undervoltage");
endmodule // oms_sup_asserts
bind oms_operation_mode_supervisor oms_sup_asserts i_chk (.i_clk, .i_rst,
  .i_low_power_ctrl, .i_direct_input_pins, .i_analog_uv, .i_logic_uv,
  .o_channel_out, .o_mode, .o_uv_monitor_en, .o_serial_enable,
  .o_serial_out_en, .o_registers_in_reset);

// >>> test/oms_host_model.sv
// Host model driving the control pins and chip select
`timescale 1ns/1ps
module oms_host_model #(
  parameter HOLD_CYC = 10
) (
  input wire i_clk,
  output logic o_low_power_ctrl = 1'b0,
  output logic [1:0] o_direct_input_pins = 2'h0,
  output logic o_chip_select_n = 1'b0 // Held selected to probe the float
);
  // New levels launch after an edge and stand for the hold time
  task set(input logic c, input logic [1:0] p);
    @(posedge i_clk);
    o_low_power_ctrl <= c;
    o_direct_input_pins <= p;
    repeat (HOLD_CYC) @(posedge i_clk);
  endtask
endmodule // oms_host_model

// >>> test/operation_mode_supervisor_tb_top.sv
// Testbench for the operation mode supervisor
`timescale 1ns/1ps
`include "oms_regs.vh"
module operation_mode_supervisor_tb_top;
  logic i_clk, i_rst, a_uv, a_op, l_uv, rd_en, wr_en, ctrl, cs_n;
  logic wait_rq, sen, soe, uvm, rrst, lop, slow;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0] pins, mode;
  logic [7:0] chan;
  integer miscompares = 0;
  integer checked = 0;
  oms_host_model i_host (.i_clk(i_clk), .o_low_power_ctrl(ctrl),
    .o_direct_input_pins(pins), .o_chip_select_n(cs_n));
  oms_operation_mode_supervisor i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_low_power_ctrl(ctrl), .i_direct_input_pins(pins), .i_analog_uv(a_uv),
    .i_analog_op(a_op), .i_logic_uv(l_uv), .i_logic_low_power(lop),
    .i_chip_select_n(cs_n), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_rq), .o_channel_out(chan), .o_mode(mode),
    .o_uv_monitor_en(uvm), .o_serial_enable(sen), .o_serial_out_en(soe),
    .o_slow_serial_clk(slow), .o_registers_in_reset(rrst));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge i_clk);
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus cycle; request stands until waitrequest is seen low
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge i_clk);
    rd_en <= !w;
    wr_en <= w;
    adr <= a;
    wdat <= d;
    @(posedge i_clk);
    while (wait_rq !== 1'b0) begin
      n++;
      if (n > 50) begin
        miscompares++;
        results();
      end
      @(posedge i_clk);
    end
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  // Read: data are taken at the edge where waitrequest is seen low
  task rd(input logic [3:0] a);
    acc(1'b0, a, 32'h0);
  endtask
  task results();
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {i_rst, a_op} = 2'h3;
    {a_uv, l_uv, lop, rd_en, wr_en, adr, wdat} = 0;
    cyc(3);
    i_rst <= 1'b0;
    cyc(8);
    cmp({mode, soe, uvm}, {`OMS_MODE_SLEEP, 2'h0});
    i_host.set(1'b1, 2'h0);
    cmp(mode, `OMS_MODE_IDLE);
    acc(1'b1, `OMS_REG_CTRL, 32'h1);
    cyc(4);
    cmp(chan, 8'h00);
    cyc(30);
    cmp({mode, chan, soe, sen}, {`OMS_MODE_ACTIVE, 8'h01, 2'h3});
    rd(`OMS_REG_STATUS);
    cmp({q[15:8], q[1:0]}, {8'h01, `OMS_MODE_ACTIVE});
    acc(1'b1, `OMS_REG_CTRL, 32'h100);
    cyc(30);
    cmp({mode, chan}, {`OMS_MODE_ACTIVE, 8'h00});
    acc(1'b1, `OMS_REG_CTRL, 32'hFF);
    cyc(30);
    {a_uv, a_op} <= 2'h2;
    cyc(8);
    cmp(chan, 8'h00);
    {a_uv, a_op} <= 2'h1;
    cyc(30);
    cmp(chan, 8'hFF);
    l_uv <= 1'b1;
    cyc(6);
    cmp({sen, rrst}, 2'h1);
    l_uv <= 1'b0;
    rd(`OMS_REG_CTRL);
    cmp(q[8:0], `OMS_CTRL_RESET);
    lop <= 1'b1;
    cyc(4);
    cmp(slow, 1'b1);
    lop <= 1'b0;
    i_host.set(1'b0, 2'h3);
    cyc(30);
    cmp({mode, chan}, {`OMS_MODE_LIMP, 8'h0C});
    acc(1'b1, `OMS_REG_CTRL, 32'h1);
    rd(`OMS_REG_CTRL);
    cmp(q[8:0], `OMS_CTRL_RESET);
    rd(`OMS_REG_STATUS);
    cmp(q[2:0], {1'b1, `OMS_MODE_LIMP});
    {a_uv, a_op} <= 2'h2;
    cyc(8);
    cmp({mode, chan}, {`OMS_MODE_LIMP, 8'h00});
    {a_uv, a_op} <= 2'h1;
    i_host.set(1'b1, 2'h1);
    cmp(mode, `OMS_MODE_ACTIVE);
    i_host.set(1'b0, 2'h0);
    cmp({mode, chan}, {`OMS_MODE_SLEEP, 8'h00});
    results();
  end
endmodule // operation_mode_supervisor_tb_top
